/* File: bench/codec_chan_ctrl_tb_top.sv */
// testbench: registers, pin hold, dac start-up and adc transmit scenarios
`timescale 1ns/100ps
module codec_chan_ctrl_tb_top
    import codec_ctrl_pkg::*;
;
    localparam int CYC_LIMIT = 10000;
    logic        mclk;
    logic        reset;
    reg_req_t    reg_req;
    logic [15:0] reg_rdata;
    logic        reset_pin_n;
    logic        power_down_pin_n;
    logic        conversion_clock_pdn_status;
    logic        frame_sync_pin;
    logic        conversion_clock;
    sample_t     adc_left_in;
    sample_t     adc_right_in;
    logic [1:0]  dac_word_valid;
    sample_t     adc_left_tx;
    sample_t     adc_right_tx;
    logic [1:0]  dac_request;
    logic [1:0]  dac_convert;
    logic [1:0]  adc_sampling;
    power_word_t power_active;
    logic [15:0] mix_level;
    logic [15:0] dac1_level;
    logic [15:0] dac2_level;
    int          miscompares = 0;
    int          compares    = 0;
    int          cyc = 0;
    int          cnt_l = 0;
    int          cnt_r = 0;
    int          t_l = 0;
    int          t_r = 0;
    logic [15:0] dat_l;
    logic [15:0] dat_r;
    logic [15:0] code0 [4] = '{16'h0080, 16'h0000, 16'h00ff, 16'h00d5};

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    codec_chan_ctrl i_dut (.mclk(mclk), .reset(reset), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reset_pin_n(reset_pin_n),
        .power_down_pin_n(power_down_pin_n), .conversion_clock_pdn_status(conversion_clock_pdn_status),
        .frame_sync_pin(frame_sync_pin), .conversion_clock(conversion_clock),
        .adc_left_in(adc_left_in), .adc_right_in(adc_right_in),
        .dac_word_valid(dac_word_valid), .adc_left_tx(adc_left_tx),
        .adc_right_tx(adc_right_tx), .dac_request(dac_request), .dac_convert(dac_convert),
        .adc_sampling(adc_sampling), .power_active(power_active), .mix_level(mix_level),
        .dac1_level(dac1_level), .dac2_level(dac2_level));

    host_port_model i_host (.mclk(mclk), .reset(reset), .dac_request(dac_request),
        .frame_sync_pin(frame_sync_pin), .conversion_clock(conversion_clock),
        .dac_word_valid(dac_word_valid));

    // transmit pulses are one cycle long, so count and stamp them here
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (adc_left_tx.valid === 1'b1) begin
            cnt_l <= cnt_l + 1;
            dat_l <= adc_left_tx.data;
            t_l   <= cyc;
        end
        if (adc_right_tx.valid === 1'b1) begin
            cnt_r <= cnt_r + 1;
            dat_r <= adc_right_tx.data;
            t_r   <= cyc;
        end
    end

    // hang guard
    always @(posedge mclk) begin
        if (cyc == CYC_LIMIT) begin
            miscompares++;
            complete_run();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
        reg_req <= '0;
    endtask : reg_wr

    // read data is loaded in the cycle after the strobe and held until the next read
    task automatic rd_chk(input string what, input logic [4:0] a, input logic [15:0] exp);
        @(posedge mclk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge mclk);
        reg_req <= '0;
        // taken at the edge that closes the cycle in which the data stand
        @(posedge mclk);
        check(what, reg_rdata, exp);
    endtask : rd_chk

    // settle 8 cycles past the pin edge: sync delay plus frame apply
    task automatic wait_fr(input int n);
        repeat (n) @(posedge frame_sync_pin);
        repeat (8) @(posedge mclk);
    endtask : wait_fr

    task automatic send_smp(input logic l, input logic r, input logic [15:0] d);
        @(posedge mclk);
        adc_left_in  <= '{valid: l, data: d};
        adc_right_in <= '{valid: r, data: d};
        @(posedge mclk);
        adc_left_in  <= '0;
        adc_right_in <= '0;
    endtask : send_smp

    task automatic t_regs();
        check("power_active", power_active, PWR_RESET);
        rd_chk("power word", OFS_PWR, PWR_RESET);
        rd_chk("format word", OFS_FMT, FMT_RESET);
        rd_chk("unmapped", 5'h1c, 16'h0000);
        reg_wr(OFS_PWR, PWR_MASK); // reserved bits left zero
        reg_wr(OFS_FMT, 16'h000f); // no lock while adcs get enabled
        rd_chk("power word", OFS_PWR, PWR_MASK);
        rd_chk("format word", OFS_FMT, 16'h000f);
        wait_fr(1);
        check("power_active", power_active, PWR_MASK);
        check("sharing", power_active.resource_sharing, 16'h0001);
        $display("end of register test");
    endtask : t_regs

    task automatic t_pins();
        for (int i = 0; i < 3; i++) begin
            reg_wr(OFS_PWR, 16'h00c3);
            reg_wr(OFS_FMT, 16'h0005);
            @(posedge mclk);
            if (i == 0) reset_pin_n <= 1'b0;
            else if (i == 1) power_down_pin_n <= 1'b0;
            else conversion_clock_pdn_status <= 1'b1;
            repeat (4) @(posedge mclk);
            reg_wr(OFS_PWR, 16'h00c3);
            reg_wr(OFS_FMT, 16'h0005);
            rd_chk("power held", OFS_PWR, PWR_RESET);
            rd_chk("format held", OFS_FMT, (i < 2) ? FMT_RESET : 16'h0005);
            reset_pin_n      <= 1'b1;
            power_down_pin_n <= 1'b1;
            conversion_clock_pdn_status  <= 1'b0;
            repeat (4) @(posedge mclk);
        end
        $display("end of pin hold test");
    endtask : t_pins

    task automatic t_dac();
        wait_fr(1);
        reg_wr(OFS_DAC1LVL, 16'h00aa);
        rd_chk("dac1 level off", OFS_DAC1LVL, 16'h0000);
        reg_wr(OFS_PWR, 16'h13c0);
        repeat (3) @(posedge mclk);
        check("request early", dac_request, 16'h0000);
        reg_wr(OFS_MIX, 16'h0033);
        reg_wr(OFS_DAC1LVL, 16'h0011);
        reg_wr(OFS_DAC2LVL, 16'h0022);
        rd_chk("mix level", OFS_MIX, 16'h0033);
        check("dac1 level", dac1_level, 16'h0011);
        check("dac2 level", dac2_level, 16'h0022);
        wait_fr(1);
        check("request on", dac_request, 16'h0003);
        wait_fr(4);
        check("convert fifth", dac_convert, 16'h0000);
        wait_fr(1);
        check("convert sixth", dac_convert, 16'h0000);
        repeat (40) @(posedge mclk);
        check("converting", dac_convert, 16'h0003);
        reg_wr(OFS_PWR, 16'h12c0);
        @(posedge mclk);
        #1 check("request off", dac_request, 16'h0002);
        check("dac1 cleared", dac1_level, 16'h0000);
        reg_wr(OFS_PWR, 16'h00c0);
        repeat (2) @(posedge mclk);
        check("mix cleared", mix_level, 16'h0000);
        check("dac2 cleared", dac2_level, 16'h0000);
        $display("end of dac test");
    endtask : t_dac

    task automatic t_pair();
        int n;
        int m;
        reg_wr(OFS_FMT, 16'h0015); // lock set while both adcs are down
        reg_wr(OFS_PWR, 16'h00c3); // equal adc enables under lock
        wait_fr(8);
        check("adc sampling", adc_sampling, 16'h0003);
        n = cnt_l;
        m = cnt_r;
        send_smp(1'b1, 1'b0, 16'h0042);
        wait_fr(1);
        check("left withheld", 16'(cnt_l - n), 16'h0000);
        rd_chk("status", OFS_STAT, 16'h0031);
        send_smp(1'b0, 1'b1, 16'h0043);
        wait_fr(1);
        check("left sent", 16'(cnt_l - n), 16'h0001);
        check("right sent", 16'(cnt_r - m), 16'h0001);
        check("same cycle", 16'(t_l - t_r), 16'h0000);
        check("left data", dat_l, 16'h0042);
        check("right data", dat_r, 16'h0043);
        reg_wr(OFS_FMT, 16'h0005); // lock cleared while running
        wait_fr(1);
        send_smp(1'b1, 1'b0, 16'h0044);
        wait_fr(1);
        check("left alone", 16'(cnt_l - n), 16'h0002);
        check("right idle", 16'(cnt_r - m), 16'h0001);
        $display("end of pair lock test");
    endtask : t_pair

    task automatic t_fmt();
        int n;
        for (int f = 0; f < 4; f++) begin
            reg_wr(OFS_FMT, 16'((f << 2) | (3 - f)));
            wait_fr(1);
            send_smp(1'b1, 1'b1, 16'h0000);
            wait_fr(1);
            check("left coded", dat_l, code0[f]);
            check("right coded", dat_r, code0[3 - f]);
        end
        reg_wr(OFS_PWR, 16'h00c0); // both adcs stop together
        repeat (2) @(posedge mclk);
        check("adc until frame", adc_sampling, 16'h0003);
        wait_fr(1);
        check("adc stopped", adc_sampling, 16'h0000);
        n = cnt_l;
        send_smp(1'b1, 1'b1, 16'h0000);
        wait_fr(1);
        check("no output", 16'(cnt_l - n), 16'h0000);
        $display("end of format test");
    endtask : t_fmt

    task automatic complete_run();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        reset            = 1'b1;
        reg_req          = '0;
        reset_pin_n      = 1'b1;
        power_down_pin_n = 1'b1;
        conversion_clock_pdn_status  = 1'b0;
        adc_left_in      = '0;
        adc_right_in     = '0;
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        repeat (5) @(posedge mclk);
        t_regs();
        t_pins();
        t_dac();
        t_pair();
        t_fmt();
        complete_run();
    end
endmodule : codec_chan_ctrl_tb_top

/* File: bench/host_port_model.sv */
// host serial port model: frame sync, conversion clock and dac word delivery
`timescale 1ns/100ps
module host_port_model (
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic [1:0] dac_request,
    output logic            frame_sync_pin,
    output logic            conversion_clock,
    output logic [1:0]      dac_word_valid
);
    logic       link_clk = 1'b0;
    logic [2:0] div_ff   = 3'h0;
    logic [2:0] fs_sync_ff;

    // link clock free running at 12 mclk periods, odd start offset keeps its edges off the mclk edges
    initial begin
        #7;
        forever #24 link_clk = ~link_clk;
    end

    // frame every 8 link clocks, conversion edge 2 link clocks after the frame edge
    always @(posedge link_clk) div_ff <= div_ff + 3'h1;
    assign frame_sync_pin   = div_ff[2];
    assign conversion_clock = div_ff[1];

    // one word per frame for each dac that asks, only while it asks
    always @(posedge mclk) begin
        if (reset) begin
            fs_sync_ff     <= 3'h0;
            dac_word_valid <= 2'h0;
        end else begin
            fs_sync_ff     <= {fs_sync_ff[1:0], frame_sync_pin};
            dac_word_valid <= (fs_sync_ff[2:1] == 2'b01) ? dac_request : 2'h0;
        end
    end
endmodule : host_port_model

/* File: common/codec_ctrl_pkg.sv */
// package: register map, field layouts and start-up counts for the channel control block
package codec_ctrl_pkg;
    localparam int          ADDR_W      = 5;
    localparam int          DATA_W      = 16;
    // register offsets (word index on the control port)
    localparam logic [4:0]  OFS_MIX     = 5'h03;
    localparam logic [4:0]  OFS_DAC1LVL = 5'h09;
    localparam logic [4:0]  OFS_DAC2LVL = 5'h0a;
    localparam logic [4:0]  OFS_FMT     = 5'h1a;
    localparam logic [4:0]  OFS_PWR     = 5'h1b;
    localparam logic [4:0]  OFS_STAT    = 5'h1f;
    // reset values and writable-bit masks
    localparam logic [15:0] PWR_RESET   = 16'h00c0;
    localparam logic [15:0] PWR_MASK    = 16'h93d3;
    localparam logic [15:0] FMT_RESET   = 16'h0000;
    localparam logic [15:0] FMT_MASK    = 16'h001f;
    // sample coding selections
    localparam logic [1:0]  FMT_U8      = 2'h0;
    localparam logic [1:0]  FMT_S16     = 2'h1;
    localparam logic [1:0]  FMT_ULAW    = 2'h2;
    localparam logic [1:0]  FMT_ALAW    = 2'h3;
    // start-up sequencing
    localparam logic [2:0]  START_EDGES = 3'h6;
    localparam logic [2:0]  FILL_WORDS  = 3'h4;

    typedef struct packed {
        logic       resource_sharing;
        logic [1:0] rsv13;
        logic       dac_mix_enable;
        logic [1:0] rsv10;
        logic       second_dac_enable;
        logic       first_dac_enable;
        logic       analog_enable;
        logic       headphone_enable;
        logic       rsv5;
        logic       analog_mix_enable;
        logic [1:0] rsv2;
        logic       right_adc_enable;
        logic       left_adc_enable;
    } power_word_t;

    typedef struct packed {
        logic [10:0] rsv5;
        logic        adc_pair_lock;
        logic [1:0]  left_adc_format;
        logic [1:0]  right_adc_format;
    } fmt_word_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } sample_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } reg_req_t;
endpackage : codec_ctrl_pkg

/* File: hdl/chan_start_seq.sv */
// module: per-channel start sequencer, frame-sync edge count then conversion-clock start
`timescale 1ns/100ps
module chan_start_seq
    import codec_ctrl_pkg::*;
(
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic enable,
    input  wire logic fs_rise,
    input  wire logic conversion_clock_rise,
    output logic      running
);
    typedef enum logic [3:0] {
        S_IDLE  = 4'b0001,
        S_COUNT = 4'b0010,
        S_ARMED = 4'b0100,
        S_RUN   = 4'b1000
    } seq_state_t;

    seq_state_t state_ff;
    seq_state_t nxt_state;
    logic [2:0] cnt_ff;
    logic [2:0] nxt_cnt;

    // edges counted from the enable; same-frame enables meet the same edge
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        case (state_ff)
            S_IDLE: begin
                nxt_cnt = 3'h0;
                if (enable) nxt_state = S_COUNT;
            end
            S_COUNT: begin
                if (fs_rise) nxt_cnt = cnt_ff + 3'h1;
                if (fs_rise && (cnt_ff + 3'h1 == START_EDGES)) nxt_state = S_ARMED;
            end
            S_ARMED: begin
                if (conversion_clock_rise) nxt_state = S_RUN;
            end
            S_RUN:   nxt_state = S_RUN;
            default: nxt_state = S_IDLE;
        endcase
        if (!enable) nxt_state = S_IDLE;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_ff <= S_IDLE;
            cnt_ff   <= 3'h0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    assign running = (state_ff == S_RUN);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    arm_on_sixth_a: assert property ((state_ff == S_COUNT) && enable && fs_rise
        && (cnt_ff == 3'h5) |=> state_ff == S_ARMED) else $error("not armed at sixth edge");
    start_on_conversion_clock_a: assert property ($rose(running) |-> $past(conversion_clock_rise)
        && $past(state_ff == S_ARMED)) else $error("start not on conversion edge");
endmodule : chan_start_seq

/* File: hdl/codec_chan_ctrl.sv */
// module: channel power, ADC format and pair-lock control for the serial codec
//
// Behaviour
// - pair lock on: left and right samples go out together only when both ready.
// - pair lock off: each sample goes out on its own at the next frame-sync edge.
// - right ADC samples coded per right format: u8, s16, mu-law, A-law.
// - left ADC samples coded per left format, same four codings.
// - format word resets to zero and is held while reset or power-down pin low.
// - resource sharing bit lends idle channel resources to enabled channels; here the bit is only stored and shown on power_active.
// - mix disabled holds register 3 at default, ignoring writes.
// - clearing a DAC enable stops its sample requests at once.
// - setting a DAC enable resumes requests from the next frame.
// - conversion starts at first conversion edge after sixth frame-sync edge.
// - channels enabled in one frame start on the same conversion edge.
// - each DAC fills its four-word buffer before converting.
// - DAC2 disabled holds level register 10 at default.
// - DAC1 disabled holds level register 9 at default.
// - power word bit positions for all enable fields.
// - ADC disable stops output after current frame; enable starts after six syncs.
// - power word resets to 00c0, held under pins low or global power-down.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps
module codec_chan_ctrl
    import codec_ctrl_pkg::*;
#(
    parameter logic [15:0] MIX_DEFAULT  = 16'h0000,
    parameter logic [15:0] DAC1_DEFAULT = 16'h0000,
    parameter logic [15:0] DAC2_DEFAULT = 16'h0000
) (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire reg_req_t    reg_req,
    output logic      [15:0] reg_rdata,
    input  wire logic        reset_pin_n,
    input  wire logic        power_down_pin_n,
    input  wire logic        conversion_clock_pdn_status,
    input  wire logic        frame_sync_pin,
    input  wire logic        conversion_clock,
    input  wire sample_t     adc_left_in,
    input  wire sample_t     adc_right_in,
    input  wire logic [1:0]  dac_word_valid,
    output sample_t          adc_left_tx,
    output sample_t          adc_right_tx,
    output logic      [1:0]  dac_request,
    output logic      [1:0]  dac_convert,
    output logic      [1:0]  adc_sampling,
    output power_word_t      power_active,
    output logic      [15:0] mix_level,
    output logic      [15:0] dac1_level,
    output logic      [15:0] dac2_level
);
    // pins: 0 reset, 1 power-down, 2 frame sync, 3 conversion clock
    logic [3:0]  pin_lvl;
    logic [3:0]  pin_rise;
    logic        fs_rise;
    logic        conversion_clock_rise;
    logic        hold_all;
    logic        pwr_hold;

    power_word_t pwr_ff;
    power_word_t act_ff;
    power_word_t nxt_act;
    fmt_word_t   fmt_ff;
    fmt_word_t   fmt_act_ff;
    logic [15:0] mix_ff;
    logic [15:0] dac1_ff;
    logic [15:0] dac2_ff;
    logic [15:0] rdata_ff;
    logic [2:0]  fill_ff [2];
    logic [3:0]  run;
    logic        lpend_ff;
    logic        rpend_ff;
    logic [15:0] ldata_ff;
    logic [15:0] rdata_s_ff;
    sample_t     ltx_ff;
    sample_t     rtx_ff;

    pin_sync #(.W(4)) u_sync (
        .mclk  (mclk),
        .reset (reset),
        .pin   ({conversion_clock, frame_sync_pin, power_down_pin_n, reset_pin_n}),
        .level (pin_lvl),
        .rise  (pin_rise)
    );

    assign fs_rise   = pin_rise[2];
    assign conversion_clock_rise = pin_rise[3];
    assign hold_all  = ~pin_lvl[0] | ~pin_lvl[1];
    assign pwr_hold  = hold_all | conversion_clock_pdn_status;

    // compand or reformat one 16-bit converter sample
    function automatic logic [15:0] encode_sample(input logic [1:0] fmt, input logic [15:0] x);
        logic        sgn;
        logic [15:0] mag;
        logic [15:0] b;
        logic [2:0]  ex;
        logic [15:0] m;
        logic [7:0]  c;
        sgn = x[15];
        mag = sgn ? (~x + 16'h0001) : x;
        ex  = 3'h0;
        c   = 8'h00;
        if (fmt == FMT_ULAW) begin
            b = mag >> 2;
            if (b > 16'h1fde) b = 16'h1fde;                        // clip before bias
            b = b + 16'h0021;
            for (int i = 0; i < 8; i++) if (b[i+5]) ex = 3'(i);
            m = b >> ({1'b0, ex} + 4'h1);                          // segment 7 shifts by 8
            c = ~{sgn, ex, m[3:0]};
        end else begin
            b = mag >> 3;
            if (b > 16'h0fff) b = 16'h0fff;
            for (int i = 5; i < 12; i++) if (b[i]) ex = 3'(i - 4);
            m = b >> ((ex == 3'h0) ? 3'h1 : ex);
            c = {~sgn, ex, m[3:0]} ^ 8'h55;
        end
        case (fmt)
            FMT_U8:   return {8'h00, x[15:8] ^ 8'h80};
            FMT_S16:  return x;
            default:  return {8'h00, c};
        endcase
    endfunction : encode_sample

    // write decode
    wire wr_pwr  = reg_req.wr && (reg_req.addr == OFS_PWR);
    wire wr_fmt  = reg_req.wr && (reg_req.addr == OFS_FMT);
    wire wr_mix  = reg_req.wr && (reg_req.addr == OFS_MIX);
    wire wr_dac1 = reg_req.wr && (reg_req.addr == OFS_DAC1LVL);
    wire wr_dac2 = reg_req.wr && (reg_req.addr == OFS_DAC2LVL);

    // reserved bits always read zero whatever the host writes
    wire [15:0] status_word = {4'h0, fill_ff[1], fill_ff[0], run, rpend_ff, lpend_ff};
    wire [15:0] rd_sel =
        (reg_req.addr == OFS_PWR)     ? pwr_ff  :
        (reg_req.addr == OFS_FMT)     ? fmt_ff  :
        (reg_req.addr == OFS_MIX)     ? mix_ff  :
        (reg_req.addr == OFS_DAC1LVL) ? dac1_ff :
        (reg_req.addr == OFS_DAC2LVL) ? dac2_ff :
        (reg_req.addr == OFS_STAT)    ? status_word : 16'h0000;

    // software-visible words with their hold conditions
    always_ff @(posedge mclk) begin
        if (reset || pwr_hold) pwr_ff <= PWR_RESET;
        else if (wr_pwr) pwr_ff <= reg_req.wdata & PWR_MASK;
        if (reset || hold_all) fmt_ff <= FMT_RESET;
        else if (wr_fmt) fmt_ff <= reg_req.wdata & FMT_MASK;
    end

    // level registers cleared while their path is powered down
    always_ff @(posedge mclk) begin
        if (reset || !pwr_ff.dac_mix_enable) mix_ff <= MIX_DEFAULT;
        else if (wr_mix) mix_ff <= reg_req.wdata;
        if (reset || !pwr_ff.first_dac_enable) dac1_ff <= DAC1_DEFAULT;
        else if (wr_dac1) dac1_ff <= reg_req.wdata;
        if (reset || !pwr_ff.second_dac_enable) dac2_ff <= DAC2_DEFAULT;
        else if (wr_dac2) dac2_ff <= reg_req.wdata;
    end

    always_ff @(posedge mclk) begin
        if (reset) rdata_ff <= 16'h0000;
        else if (reg_req.rd) rdata_ff <= rd_sel;
    end

    // settings move to the active copy on frame edges; DAC disables act at once
    always_comb begin
        nxt_act = fs_rise ? pwr_ff : act_ff;
        nxt_act.first_dac_enable  = nxt_act.first_dac_enable & pwr_ff.first_dac_enable;
        nxt_act.second_dac_enable = nxt_act.second_dac_enable & pwr_ff.second_dac_enable;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            act_ff     <= PWR_RESET;
            fmt_act_ff <= FMT_RESET;
        end else begin
            act_ff <= nxt_act;
            if (fs_rise) fmt_act_ff <= fmt_ff;
        end
    end

    // one sequencer per channel: 0 DAC1, 1 DAC2, 2 left ADC, 3 right ADC
    // adc sequencers keep running until the frame edge applies a disable
    wire [3:0] seq_en = {pwr_ff.right_adc_enable | act_ff.right_adc_enable,
                         pwr_ff.left_adc_enable | act_ff.left_adc_enable,
                         pwr_ff.second_dac_enable, pwr_ff.first_dac_enable};
    for (genvar g = 0; g < 4; g++) begin : g_seq
        chan_start_seq u_seq (
            .mclk      (mclk),
            .reset     (reset),
            .enable    (seq_en[g]),
            .fs_rise   (fs_rise),
            .conversion_clock_rise (conversion_clock_rise),
            .running   (run[g])
        );
    end

    // DAC buffer fill during start-up, saturating at four words
    for (genvar d = 0; d < 2; d++) begin : g_fill
        always_ff @(posedge mclk) begin
            if (reset || !seq_en[d]) fill_ff[d] <= 3'h0;
            else if (dac_word_valid[d] && fill_ff[d] != FILL_WORDS)
                fill_ff[d] <= fill_ff[d] + 3'h1;
        end
        assign dac_convert[d] = run[d] && (fill_ff[d] == FILL_WORDS);
    end

    assign dac_request  = {act_ff.second_dac_enable, act_ff.first_dac_enable};
    assign adc_sampling = {run[3] & act_ff.right_adc_enable,
                           run[2] & act_ff.left_adc_enable};

    // frame-time release of pending ADC samples
    wire lock   = fmt_act_ff.adc_pair_lock;
    wire send_l = fs_rise && lpend_ff && (!lock || rpend_ff);
    wire send_r = fs_rise && rpend_ff && (!lock || lpend_ff);
    wire cap_l  = adc_left_in.valid && adc_sampling[0];
    wire cap_r  = adc_right_in.valid && adc_sampling[1];

    // a new sample in the send cycle stays pending, so it is not lost
    always_ff @(posedge mclk) begin
        if (reset || !adc_sampling[0]) lpend_ff <= 1'b0;
        else if (cap_l) lpend_ff <= 1'b1;
        else if (send_l) lpend_ff <= 1'b0;
        if (reset || !adc_sampling[1]) rpend_ff <= 1'b0;
        else if (cap_r) rpend_ff <= 1'b1;
        else if (send_r) rpend_ff <= 1'b0;
    end

    always_ff @(posedge mclk) begin
        if (cap_l) ldata_ff <= adc_left_in.data;
        if (cap_r) rdata_s_ff <= adc_right_in.data;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            ltx_ff <= '0;
            rtx_ff <= '0;
        end else begin
            ltx_ff <= {send_l, encode_sample(fmt_act_ff.left_adc_format, ldata_ff)};
            rtx_ff <= {send_r, encode_sample(fmt_act_ff.right_adc_format, rdata_s_ff)};
        end
    end

    assign adc_left_tx  = ltx_ff;
    assign adc_right_tx = rtx_ff;
    assign reg_rdata    = rdata_ff;
    assign power_active = act_ff;
    assign mix_level    = mix_ff;
    assign dac1_level   = dac1_ff;
    assign dac2_level   = dac2_ff;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    pwr_hold_a: assert property (pwr_hold |=> pwr_ff == PWR_RESET)
        else $error("power word not held");
    fmt_hold_a: assert property (hold_all ##1 hold_all |-> fmt_ff == FMT_RESET)
        else $error("format word not held");
    mix_hold_a: assert property (!pwr_ff.dac_mix_enable |=> mix_ff == MIX_DEFAULT)
        else $error("mix level not held");
    dac1_hold_a: assert property (!pwr_ff.first_dac_enable |=> dac1_ff == DAC1_DEFAULT)
        else $error("dac1 level not held");
    dac2_hold_a: assert property (!pwr_ff.second_dac_enable |=> dac2_ff == DAC2_DEFAULT)
        else $error("dac2 level not held");
    dac_stop_a: assert property ($fell(pwr_ff.first_dac_enable) |=> !dac_request[0])
        else $error("dac1 request not stopped");
    dac_resume_a: assert property ($rose(dac_request[0]) |-> $past(fs_rise))
        else $error("dac1 request not on frame edge");
    pair_send_a: assert property (adc_left_tx.valid && $past(lock) |-> adc_right_tx.valid)
        else $error("locked pair split");
    single_send_a: assert property (fs_rise && lpend_ff && !lock && adc_sampling[0]
        |=> adc_left_tx.valid) else $error("left sample withheld");
    fill_first_a: assert property ($rose(dac_convert[0]) |-> fill_ff[0] == FILL_WORDS
        && run[0]) else $error("dac1 converts unfilled");

    pair_cov: cover property (adc_left_tx.valid && adc_right_tx.valid && $past(lock));
    conversion_clock_cov: cover property ($rose(dac_convert[1]));
    hold_cov: cover property (wr_pwr && pwr_hold);
endmodule : codec_chan_ctrl

/* File: hdl/pin_sync.sv */
// module: two-flop synchroniser with rising-edge detect for a group of pins
`timescale 1ns/100ps
module pin_sync #(
    parameter int W = 4
) (
    input  wire logic         mclk,
    input  wire logic         reset,
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;
    logic [W-1:0] last_ff;

    // elaboration check: an empty pin group cannot be served
    if (W < 1) begin : g_bad_w
        $error("pin_sync: W must be at least 1");
    end

    // meta_ff feeds only sync_ff
    always_ff @(posedge mclk) begin
        if (reset) begin
            meta_ff <= '0;
            sync_ff <= '0;
            last_ff <= '0;
        end else begin
            meta_ff <= pin;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    assign level = sync_ff;
    assign rise  = sync_ff & ~last_ff;
endmodule : pin_sync
